// ### verilog/avsc_pkg.sv
//
// Contract
// - revision register always reads fixed value
// - decode full serial command set
// - voltage adjust sets seven-bit code
// - strap address latched while initialising (after bias rise or pin reset)
// - strap level maps to addresses 0..7
// - regulator enable follows on/off input
// - bias rise: ready within 100 us
// - bias low forces shutdown
// - buck enable is control AND ready AND active state
// - control selects active/sleep, reloads code from default register
// - fault low holds code at the default register value (resets 7F)
// - fault high re-allows code writes
// - reset pin is separate level reset
// - commands and pins steer buck enable
// - two wires: clock and bidirectional data
// - drive seven-bit current DAC code
// - code bit7 zero, resets 7F
// - sleep disables DAC, registers stay accessible
package avsc_pkg;
  // ****************************************
  // commands and frame layout
  // ****************************************
  localparam logic [3:0] CMD_CORE_ADJ = 4'h1;
  localparam logic [3:0] CMD_RESET = 4'h2;
  localparam logic [3:0] CMD_SLEEP = 4'h3;
  localparam logic [3:0] CMD_SHUTDOWN = 4'h4;
  localparam logic [3:0] CMD_WAKEUP = 4'h5;
  localparam logic [3:0] CMD_REG_READ = 4'h6;
  localparam logic [3:0] CMD_REG_WRITE = 4'h7;
  localparam logic [3:0] CMD_AUTH = 4'h8;
  localparam logic [3:0] CMD_SYNC = 4'h9;
  localparam int FRAME_BITS = 22;
  localparam int REPLY_BITS = 9;
  // ****************************************
  // registers
  // ****************************************
  localparam logic [7:0] ADDR_CURRENT_INJ = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_CAPABILITY = 8'h04;
  localparam logic [7:0] ADDR_DEFAULT = 8'h09;
  localparam logic [7:0] ADDR_RAMP = 8'h0A;
  localparam logic [7:0] ADDR_REVISION = 8'h7F;
  localparam logic [6:0] CODE_RESET = 7'h7F;
  localparam logic [7:0] RAMP_RESET = 8'h9C;
  localparam logic [7:0] CAPABILITY_VALUE = 8'h02;
  localparam logic [7:0] AUTH_REPLY = 8'hA5;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int INIT_US = 100;
  localparam int INIT_CYCLES = INIT_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_SHUTDOWN, ST_INIT, ST_ACTIVE, ST_SLEEP} avsc_state_type;
endpackage : avsc_pkg

// ### verilog/avsc_top.sv
`timescale 1ns/1ps
module avsc_top import avsc_pkg::*; #(
  parameter int INIT_COUNT = INIT_CYCLES,
  parameter logic [7:0] REVISION_ID = 8'h5A // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic reset_in_low,
  input wire logic on_off,
  input wire logic bias_turn_on,
  input wire logic control_in,
  input wire logic fault_in_low,
  input wire logic [2:0] strap_level,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic ldo_output,
  output logic buck_stage_turn_on,
  output logic dac_enable,
  output logic [6:0] injection_current_code,
  output logic ready
);
  initial begin
    if (INIT_COUNT < 1 || INIT_COUNT > INIT_CYCLES) $error("init count out of range");
  end
  // ****************************************
  // reset release and input sync
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  localparam int NS = 7;
  logic [NS-1:0] s1_q, s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: reset and fault pins high, so no false reset after release
      s1_q <= 7'h44;
      s2_q <= 7'h44;
    end else begin
      s1_q <= {reset_in_low, on_off, bias_turn_on, control_in, fault_in_low, serial_clk, serial_data_in};
      s2_q <= s1_q;
    end
  end
  wire rstin_s = s2_q[6];
  wire onoff_s = s2_q[5];
  wire bias_s = s2_q[4];
  wire ctl_s = s2_q[3];
  wire flt_s = s2_q[2];
  wire sclk_s = s2_q[1];
  wire sdat_s = s2_q[0];
  logic [2:0] strap1_q, strap2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap1_q <= 3'h0;
      strap2_q <= 3'h0;
    end else begin
      strap1_q <= strap_level;
      strap2_q <= strap1_q;
    end
  end
  // logic reset from pin, separate from bias and control
  wire lrst = !rstin_s;
  // ****************************************
  // state sequencing
  // ****************************************
  avsc_state_type state_q, state_d;
  logic bias_q, ctl_q, sclk_q;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt_q;
  logic [2:0] addr_q;
  logic cmd_sleep, cmd_wake, cmd_shut;
  wire bias_rise = bias_s && !bias_q;
  wire ctl_change = ctl_s != ctl_q;
  wire init_done = init_cnt_q == ($clog2(INIT_CYCLES+1))'(INIT_COUNT - 1);
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SHUTDOWN: if (bias_rise) state_d = ST_INIT;
      ST_INIT: if (init_done) state_d = ctl_s ? ST_ACTIVE : ST_SLEEP;
      ST_ACTIVE: begin
        if (cmd_shut) state_d = ST_SHUTDOWN;
        else if (cmd_sleep || (ctl_change && !ctl_s)) state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (cmd_shut) state_d = ST_SHUTDOWN;
        else if (cmd_wake || (ctl_change && ctl_s)) state_d = ST_ACTIVE;
      end
      default: state_d = ST_SHUTDOWN;
    endcase
    if (!bias_s) state_d = ST_SHUTDOWN;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_SHUTDOWN;
      bias_q <= 1'b0;
      ctl_q <= 1'b0;
      sclk_q <= 1'b0;
      init_cnt_q <= '0;
    end else begin
      state_q <= lrst ? (bias_s ? ST_INIT : ST_SHUTDOWN) : state_d;
      bias_q <= bias_s;
      ctl_q <= ctl_s;
      sclk_q <= sclk_s;
      init_cnt_q <= (state_q == ST_INIT && !init_done) ? init_cnt_q + 1'b1 : '0;
    end
  end
  // strap address taken only while initialising
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) addr_q <= 3'h0;
    else if (state_q == ST_INIT) addr_q <= strap2_q;
  end
  assign ready = state_q == ST_ACTIVE || state_q == ST_SLEEP;
  // ****************************************
  // serial frame receive and reply
  // ****************************************
  // frame: addr[21:19] cmd[18:15] reg[14:8] data[7:0], msb first
  logic [FRAME_BITS-1:0] sh_q;
  logic [4:0] bit_cnt_q;
  logic [REPLY_BITS-1:0] tx_q;
  logic [3:0] tx_cnt_q;
  wire sclk_rise = sclk_s && !sclk_q;
  wire sclk_fall = !sclk_s && sclk_q;
  // no receive while a reply is still on the line
  wire rx_idle = tx_cnt_q == 4'h0 && !serial_data_oe;
  wire frame_done = sclk_rise && bit_cnt_q == 5'(FRAME_BITS - 1) && rx_idle;
  wire [FRAME_BITS-1:0] frame = {sh_q[FRAME_BITS-2:0], sdat_s};
  wire [2:0] f_addr = frame[21:19];
  wire [3:0] f_cmd = frame[18:15];
  wire [6:0] f_reg = frame[14:8];
  wire [7:0] f_data = frame[7:0];
  wire for_me = frame_done && f_addr == addr_q;
  function automatic logic hit(input logic [3:0] c);
    hit = for_me && f_cmd == c;
  endfunction : hit
  assign cmd_sleep = hit(CMD_SLEEP);
  assign cmd_wake = hit(CMD_WAKEUP);
  assign cmd_shut = hit(CMD_SHUTDOWN);
  wire cmd_rst = hit(CMD_RESET);
  wire cmd_adj = hit(CMD_CORE_ADJ);
  wire cmd_wr = hit(CMD_REG_WRITE);
  wire cmd_rd = hit(CMD_REG_READ);
  wire cmd_auth = hit(CMD_AUTH);
  wire cmd_sync = hit(CMD_SYNC);
  // ****************************************
  // registers
  // ****************************************
  logic [6:0] code_q, dflt_q;
  logic [7:0] ramp_q;
  wire [7:0] reg_addr = {1'b0, f_reg};
  wire code_hold = !flt_s || ctl_change || cmd_rst || lrst;
  wire code_wr = (cmd_wr && reg_addr == ADDR_CURRENT_INJ) || cmd_adj;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= CODE_RESET;
      dflt_q <= CODE_RESET;
      ramp_q <= RAMP_RESET;
    end else begin
      if (code_hold) code_q <= dflt_q;
      else if (code_wr) code_q <= f_data[6:0];
      if (cmd_wr && reg_addr == ADDR_DEFAULT) dflt_q <= f_data[6:0];
      if (cmd_wr && reg_addr == ADDR_RAMP) ramp_q <= f_data & 8'hBF;
      if (cmd_rst) ramp_q <= RAMP_RESET;
    end
  end
  logic rd_hit;
  logic [7:0] rd_data;
  always_comb begin
    rd_hit = 1'b1;
    case (reg_addr)
      ADDR_CURRENT_INJ: rd_data = {1'b0, code_q};
      ADDR_STATUS: rd_data = {7'h07, flt_s};
      ADDR_CAPABILITY: rd_data = CAPABILITY_VALUE;
      ADDR_DEFAULT: rd_data = {1'b0, dflt_q};
      ADDR_RAMP: rd_data = ramp_q;
      ADDR_REVISION: rd_data = REVISION_ID;
      default: begin
        rd_data = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  // reply shifts out on falling serial clock edges, start bit then data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '0;
      bit_cnt_q <= 5'h0;
      tx_q <= '0;
      tx_cnt_q <= 4'h0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      if (tx_cnt_q != 4'h0) begin
        if (sclk_fall) begin
          serial_data_out <= tx_q[REPLY_BITS-1];
          serial_data_oe <= 1'b1;
          tx_q <= {tx_q[REPLY_BITS-2:0], 1'b0};
          tx_cnt_q <= tx_cnt_q - 4'h1;
        end
      end else if (sclk_fall) begin
        serial_data_oe <= 1'b0;
      end
      if (frame_done || cmd_sync) begin
        bit_cnt_q <= 5'h0;
        sh_q <= '0;
      end else if (sclk_rise && rx_idle) begin
        sh_q <= frame;
        bit_cnt_q <= bit_cnt_q + 5'h1;
      end
      if ((cmd_rd && rd_hit) || cmd_auth) begin
        tx_q <= {1'b1, cmd_auth ? AUTH_REPLY : rd_data};
        tx_cnt_q <= 4'(REPLY_BITS);
      end
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign ldo_output = onoff_s;
  assign buck_stage_turn_on = ctl_s && ready && state_q == ST_ACTIVE;
  assign dac_enable = state_q == ST_ACTIVE;
  assign injection_current_code = code_q;
endmodule : avsc_top

// ### testbench/avsc_host_model.sv
`timescale 1ns/1ps
module avsc_host_model import avsc_pkg::*; (
  output logic serial_clk,
  output logic host_data,
  input wire logic line
);
  // ******
  // frames out, replies in
  // ******
  initial begin
    serial_clk = 1'b0;
    host_data = 1'b1;
  end
  task automatic send(input logic [2:0] a, input logic [3:0] c, input logic [6:0] r, input logic [7:0] d);
    logic [21:0] f;
    f = {a, c, r, d};
    for (int i = 21; i >= 0; i--) begin
      host_data = f[i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    host_data = ~host_data;
  endtask : send
  task automatic reply(output logic [8:0] v);
    int n;
    n = 0;
    v = 9'h000;
    // an empty reply clocks one full ignored frame of zeros
    for (int i = 0; i < 22 && n < 9; i++) begin
      #80 serial_clk = 1'b1;
      if (n > 0 || line === 1'b1) begin
        v = {v[7:0], line};
        n++;
      end
      #80 serial_clk = 1'b0;
    end
  endtask : reply
endmodule : avsc_host_model

// ### testbench/avsc_top_assertions.sv
`timescale 1ns/1ps
module avsc_top_checker import avsc_pkg::*; #(
  parameter int INIT_COUNT = INIT_CYCLES
) (
  input logic ref_clk,
  input logic arst_n,
  input logic reset_in_low,
  input logic on_off,
  input logic bias_turn_on,
  input logic control_in,
  input logic fault_in_low,
  input logic serial_clk,
  input logic serial_data_out,
  input logic serial_data_oe,
  input logic ldo_output,
  input logic buck_stage_turn_on,
  input logic dac_enable,
  input logic [6:0] injection_current_code,
  input logic ready
);
  localparam int INIT_LIM = INIT_COUNT + 10;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // cycles waited for ready since a bias rise
  logic init_pend_q;
  logic [15:0] init_wait_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_pend_q <= 1'b0;
      init_wait_q <= 16'h0000;
    end else if (ready || !bias_turn_on || !reset_in_low) begin
      init_pend_q <= 1'b0;
      init_wait_q <= 16'h0000;
    end else if ($rose(bias_turn_on) || init_pend_q) begin
      init_pend_q <= 1'b1;
      init_wait_q <= init_wait_q + 16'h0001;
    end
  end
  AST_LDO: assert property ($stable(on_off) [*6] |-> ldo_output == on_off) else $error("ldo wrong");
  AST_INIT: assert property (int'(init_wait_q) <= INIT_LIM) else $error("ready late");
  AST_BIAS_LOW: assert property (!bias_turn_on [*4] |-> !ready && !buck_stage_turn_on) else $error("not off");
  AST_BUCK_AND: assert property (buck_stage_turn_on |-> ready) else $error("buck without ready");
  AST_BUCK_CTRL: assert property (!control_in [*4] |-> !buck_stage_turn_on) else $error("buck on in sleep");
  AST_FAULT: assert property (!fault_in_low [*4] |-> injection_current_code == CODE_RESET) else $error("code moved");
  AST_DAC: assert property (buck_stage_turn_on |-> dac_enable) else $error("dac off when active");
  AST_RST: assert property (!reset_in_low [*4] |-> !ready) else $error("ready in reset");
  AST_OE: assert property ($rose(serial_data_oe) |-> serial_data_out && !serial_clk) else $error("bad start");
endmodule : avsc_top_checker
bind avsc_top avsc_top_checker #(.INIT_COUNT(INIT_COUNT)) avsc_top_checker_inst (.*);

// ### testbench/avs_serial_control_logic_tb_top.sv
`timescale 1ns/1ps
module avs_serial_control_logic_tb_top;
  import avsc_pkg::*;
  localparam int INIT = 20;
  logic ref_clk = 0, arst_n = 0, reset_in_low = 1, on_off = 0, bias_turn_on = 0, control_in = 1, fault_in_low = 1;
  logic [2:0] strap_level = 3'h5;
  logic serial_clk, host_data, serial_data_out, serial_data_oe, ldo_output, buck_stage_turn_on, dac_enable, ready;
  logic [6:0] injection_current_code;
  logic [8:0] v;
  int err_count = 0, checks_done = 0;
  wire sdata = serial_data_oe ? serial_data_out : host_data;
  avsc_top #(.INIT_COUNT(INIT), .REVISION_ID(8'h3C)) avsc_top_inst (.*, .serial_data_in(sdata));
  avsc_host_model avsc_host_model_inst (.serial_clk(serial_clk), .host_data(host_data), .line(sdata));
  initial forever #5 ref_clk = ~ref_clk;
  // ******
  // access tasks
  // ******
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  task automatic fr(input logic [2:0] a, input logic [3:0] c, input logic [7:0] d);
    avsc_host_model_inst.send(a, c, 7'h00, d);
    wt(10);
  endtask : fr
  task automatic rd(input logic [3:0] c, input logic [6:0] r);
    avsc_host_model_inst.send(3'h5, c, r, 8'h01);
    avsc_host_model_inst.reply(v);
    wt(10);
  endtask : rd
  task automatic conclude;
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    wt(4);
    arst_n = 1;
    on_off = 1;
    bias_turn_on = 1;
    wt(INIT + 10);
    chk("ldo", 1, ldo_output);
    chk("ready", 1, ready);
    chk("buck", 1, buck_stage_turn_on);
    fr(3'h5, CMD_CORE_ADJ, 8'h10);
    chk("adjust", 9'h10, injection_current_code);
    fr(3'h5, CMD_REG_WRITE, 8'hC5);
    chk("write", 9'h45, injection_current_code);
    fr(3'h2, CMD_CORE_ADJ, 8'h22);
    chk("foreign", 9'h45, injection_current_code);
    rd(CMD_REG_READ, 7'h7F);
    chk("revision", 9'h13C, v);
    rd(CMD_REG_READ, 7'h00);
    chk("readback", 9'h145, v);
    rd(CMD_REG_READ, 7'h1F);
    chk("unmapped", 9'h000, v);
    rd(CMD_AUTH, 7'h00);
    chk("auth", {1'b1, AUTH_REPLY}, v);
    fault_in_low = 0;
    fr(3'h5, CMD_CORE_ADJ, 8'h11);
    chk("fault", {2'b00, CODE_RESET}, injection_current_code);
    chk("fault buck", 1, buck_stage_turn_on);
    fault_in_low = 1;
    wt(6);
    fr(3'h5, CMD_CORE_ADJ, 8'h11);
    chk("after fault", 9'h11, injection_current_code);
    control_in = 0;
    wt(6);
    chk("sleep buck", 0, buck_stage_turn_on);
    chk("sleep dac", 0, dac_enable);
    chk("reload", {2'b00, CODE_RESET}, injection_current_code);
    rd(CMD_REG_READ, 7'h00);
    chk("sleep read", {2'b10, CODE_RESET}, v);
    control_in = 1;
    wt(6);
    chk("active buck", 1, buck_stage_turn_on);
    fr(3'h5, CMD_SLEEP, 8'h00);
    chk("cmd sleep", 0, buck_stage_turn_on);
    fr(3'h5, CMD_WAKEUP, 8'h00);
    chk("cmd wake", 1, buck_stage_turn_on);
    fr(3'h5, CMD_SYNC, 8'h00);
    fr(3'h5, CMD_RESET, 8'h00);
    wt(INIT + 10);
    fr(3'h5, CMD_CORE_ADJ, 8'h33);
    chk("after sync", 9'h33, injection_current_code);
    strap_level = 3'h0;
    fr(3'h5, CMD_SHUTDOWN, 8'h00);
    chk("shutdown", 0, ready);
    bias_turn_on = 0;
    wt(6);
    chk("bias low", 0, ready);
    bias_turn_on = 1;
    wt(INIT + 10);
    fr(3'h0, CMD_CORE_ADJ, 8'h07);
    chk("new addr", 9'h07, injection_current_code);
    reset_in_low = 0;
    wt(6);
    chk("pin reset", 0, ready);
    reset_in_low = 1;
    conclude();
  end
endmodule : avs_serial_control_logic_tb_top
